// *** design/hpmdc_port_cfg.sv ***
`timescale 1ns/100ps
module hpmdc_port_cfg (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Register port
   input wire logic [hpmdc_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [hpmdc_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [hpmdc_pkg::DATA_W-1:0] reg_rdata_out,
   // Strap pins
   input wire logic internal_default_in,
   input wire logic [hpmdc_pkg::STRAP_W-1:0] fixed_attach_strap_in,
   input wire logic [hpmdc_pkg::STRAP_W-1:0] port_off_strap_in,
   // Report to the upstream side
   output logic [hpmdc_pkg::NPORT:1] port_enabled_out,
   output logic [hpmdc_pkg::NPORT*hpmdc_pkg::NUM_W-1:0] port_number_out,
   output logic [hpmdc_pkg::NUM_W-1:0] port_count_out,
   output logic [hpmdc_pkg::NPORT:1] fixed_attach_report_out,
   output logic remap_mode_out,
   output logic self_powered_out
);
   import hpmdc_pkg::*;

   localparam int unsigned PIN_W = 1 + 2 * STRAP_W;

   logic [7:0] cfg_three_q, cfg_three_d;
   logic [7:0] fixed_attach_q, fixed_attach_d;
   logic [7:0] sp_off_cfg_q, sp_off_cfg_d;
   logic [7:0] bp_off_cfg_q, bp_off_cfg_d;
   logic [7:0] sp_off_run_q, sp_off_run_d;
   logic [7:0] bp_off_run_q, bp_off_run_d;
   logic [7:0] map_one_two_q, map_one_two_d;
   logic [7:0] map_three_q, map_three_d;
   logic [7:0] power_ctrl_q, power_ctrl_d;
   logic [7:0] rdata_q, rdata_d;

   logic [PIN_W-1:0] pin_s1_q, pin_s2_q, pin_s3_q;
   logic [PIN_W-1:0] pin_stable_q, pin_stable_d;

   logic [NPORT:1] en_q, en_d;
   logic [NPORT*NUM_W-1:0] num_q, num_d;
   logic [NUM_W-1:0] cnt_q, cnt_d;
   logic [NPORT:1] fixed_rep_q, fixed_rep_d;
   logic mode_q, mode_d;
   logic self_q, self_d;

   // Pin synchroniser: the first stage feeds only the second
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
      end else begin
         pin_s1_q <= {internal_default_in, fixed_attach_strap_in, port_off_strap_in};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // A pin change is accepted once stages two and three agree, filtering glitches
   always_comb begin
      pin_stable_d = pin_stable_q;
      if (pin_s2_q == pin_s3_q) begin
         pin_stable_d = pin_s3_q;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         pin_stable_q <= '0;
      end else begin
         pin_stable_q <= pin_stable_d;
      end
   end

   // Register writes; reserved bits are never stored so they read zero
   always_comb begin
      cfg_three_d = cfg_three_q;
      fixed_attach_d = fixed_attach_q;
      sp_off_cfg_d = sp_off_cfg_q;
      bp_off_cfg_d = bp_off_cfg_q;
      sp_off_run_d = sp_off_run_q;
      bp_off_run_d = bp_off_run_q;
      map_one_two_d = map_one_two_q;
      map_three_d = map_three_q;
      power_ctrl_d = power_ctrl_q;
      if (reg_wr_in) begin
         case (reg_addr_in)
            OFS_CFG_THREE: cfg_three_d = reg_wdata_in & CFG_THREE_MASK;
            OFS_FIXED_ATTACH: fixed_attach_d = reg_wdata_in & PORT_BITS_MASK;
            OFS_SP_OFF_CFG: sp_off_cfg_d = reg_wdata_in & PORT_BITS_MASK;
            OFS_BP_OFF_CFG: bp_off_cfg_d = reg_wdata_in & PORT_BITS_MASK;
            OFS_SP_OFF_RUN: sp_off_run_d = reg_wdata_in & PORT_BITS_MASK;
            OFS_BP_OFF_RUN: bp_off_run_d = reg_wdata_in & PORT_BITS_MASK;
            OFS_MAP_ONE_TWO: map_one_two_d = reg_wdata_in;
            OFS_MAP_THREE: map_three_d = reg_wdata_in & MAP_THREE_MASK;
            OFS_POWER_CTRL: power_ctrl_d = reg_wdata_in & PWR_CTRL_MASK;
            default: ;
         endcase
      end
   end

   // Read data is captured on the strobe and stands for the next cycle only
   always_comb begin
      rdata_d = 8'h00;
      if (reg_rd_in) begin
         case (reg_addr_in)
            OFS_CFG_THREE: rdata_d = cfg_three_q;
            OFS_FIXED_ATTACH: rdata_d = fixed_attach_q;
            OFS_SP_OFF_CFG: rdata_d = sp_off_cfg_q;
            OFS_BP_OFF_CFG: rdata_d = bp_off_cfg_q;
            OFS_SP_OFF_RUN: rdata_d = sp_off_run_q;
            OFS_BP_OFF_RUN: rdata_d = bp_off_run_q;
            OFS_MAP_ONE_TWO: rdata_d = map_one_two_q;
            OFS_MAP_THREE: rdata_d = map_three_q;
            OFS_POWER_CTRL: rdata_d = power_ctrl_q;
            OFS_PORT_STATUS: rdata_d = {cnt_q, en_q, mode_q};
            OFS_FIXED_REPORT: rdata_d = {4'h0, fixed_rep_q, 1'b0};
            OFS_NUM_ONE_TWO: rdata_d = num_q[2*NUM_W-1:0];
            OFS_NUM_THREE: rdata_d = {4'h0, num_q[3*NUM_W-1:2*NUM_W]};
            default: rdata_d = 8'h00; // Unmapped reads return zero
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         cfg_three_q <= REG_RESET;
         fixed_attach_q <= REG_RESET;
         sp_off_cfg_q <= REG_RESET;
         bp_off_cfg_q <= REG_RESET;
         sp_off_run_q <= REG_RESET;
         bp_off_run_q <= REG_RESET;
         map_one_two_q <= REG_RESET;
         map_three_q <= REG_RESET;
         power_ctrl_q <= REG_RESET;
         rdata_q <= REG_RESET;
      end else begin
         cfg_three_q <= cfg_three_d;
         fixed_attach_q <= fixed_attach_d;
         sp_off_cfg_q <= sp_off_cfg_d;
         bp_off_cfg_q <= bp_off_cfg_d;
         sp_off_run_q <= sp_off_run_d;
         bp_off_run_q <= bp_off_run_d;
         map_one_two_q <= map_one_two_d;
         map_three_q <= map_three_d;
         power_ctrl_q <= power_ctrl_d;
         rdata_q <= rdata_d;
      end
   end

   // Port numbering. Disable masks hold in both modes, so a disabled port
   // is never offered to the host whichever numbering is chosen.
   always_comb begin
      logic use_strap;
      logic [7:0] off_mask;
      logic [7:0] fixed_mask;
      logic [NUM_W-1:0] running;
      logic [NUM_W-1:0] map_val;
      logic [NUM_W-1:0] lnum;
      off_mask = 8'h00;
      fixed_mask = 8'h00;
      running = '0;
      map_val = '0;
      lnum = '0;
      use_strap = pin_stable_q[PIN_W-1];
      self_d = power_ctrl_q[PWR_SRC_BIT];
      mode_d = cfg_three_q[REMAP_SEL_BIT];
      if (use_strap) begin
         off_mask = hpmdc_strap_mask(pin_stable_q[STRAP_W-1:0]);
         fixed_mask = hpmdc_strap_mask(pin_stable_q[2*STRAP_W-1:STRAP_W]);
      end else begin
         off_mask = self_d ? (sp_off_cfg_q | sp_off_run_q) : (bp_off_cfg_q | bp_off_run_q);
         fixed_mask = fixed_attach_q;
      end
      running = '0;
      en_d = '0;
      num_d = '0;
      fixed_rep_d = '0;
      for (int p = 1; p <= NPORT; p++) begin
         if (p == 1) begin
            map_val = map_one_two_q[NUM_W-1:0];
         end else if (p == 2) begin
            map_val = map_one_two_q[MAP_HI_LSB +: NUM_W];
         end else begin
            map_val = map_three_q[NUM_W-1:0];
         end
         lnum = '0;
         if (!off_mask[p]) begin
            if (mode_d) begin
               lnum = map_val;
            end else begin
               running = running + 4'h1;
               lnum = running;
            end
         end
         en_d[p] = (lnum != '0);
         num_d[(p-1)*NUM_W +: NUM_W] = lnum;
         // Report non-removable against the number the host sees
         if (lnum != '0 && lnum <= 4'(NPORT) && fixed_mask[p]) begin
            fixed_rep_d[lnum[1:0]] = 1'b1;
         end
      end
      cnt_d = '0;
      for (int p = 1; p <= NPORT; p++) begin
         cnt_d = cnt_d + {3'h0, en_d[p]};
      end
   end

   // Report registers; outputs change one cycle after the settings do
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         en_q <= '0;
         num_q <= '0;
         cnt_q <= '0;
         fixed_rep_q <= '0;
         mode_q <= 1'b0;
         self_q <= 1'b0;
      end else begin
         en_q <= en_d;
         num_q <= num_d;
         cnt_q <= cnt_d;
         fixed_rep_q <= fixed_rep_d;
         mode_q <= mode_d;
         self_q <= self_d;
      end
   end

   // Outputs
   assign reg_rdata_out = rdata_q;
   assign port_enabled_out = en_q;
   assign port_number_out = num_q;
   assign port_count_out = cnt_q;
   assign fixed_attach_report_out = fixed_rep_q;
   assign remap_mode_out = mode_q;
   assign self_powered_out = self_q;
endmodule

// *** design/hpmdc_pkg.sv ***
// Notes on behaviour
// - Config byte three bit 3 selects numbering mode
// - Standard mode, nothing off: port n reports n
// - Standard mode renumbers higher ports without gaps
// - Standard mode masks from straps or disable registers
// - Port map mode numbers ports from map registers
// - Fixed attach mask reported per active port
// - Mask bits 1 to 3 control ports; others reserved
// - Internal default: fixed attach strap sets non-removable
// - Self-powered mask disables ports, one disables
// - Disabled port never enabled nor enumerated
// - Any combination disabled; count and order reported
// - Bus-powered mask works the same way
// - Internal default: port off strap disables ports
// - Power source bit: 0 bus, 1 self
package hpmdc_pkg;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned NPORT = 3;
   localparam int unsigned NUM_W = 4;
   localparam int unsigned STRAP_W = 2;

   // Register offsets
   localparam logic [15:0] OFS_CFG_THREE = 16'h00e6;
   localparam logic [15:0] OFS_FIXED_ATTACH = 16'h00e7;
   localparam logic [15:0] OFS_SP_OFF_CFG = 16'h00e8;
   localparam logic [15:0] OFS_BP_OFF_CFG = 16'h00e9;
   localparam logic [15:0] OFS_SP_OFF_RUN = 16'h300a;
   localparam logic [15:0] OFS_BP_OFF_RUN = 16'h300b;
   localparam logic [15:0] OFS_MAP_ONE_TWO = 16'h30fb;
   localparam logic [15:0] OFS_MAP_THREE = 16'h30fc;
   localparam logic [15:0] OFS_POWER_CTRL = 16'h3100;
   localparam logic [15:0] OFS_PORT_STATUS = 16'h3110;
   localparam logic [15:0] OFS_FIXED_REPORT = 16'h3111;
   localparam logic [15:0] OFS_NUM_ONE_TWO = 16'h3112;
   localparam logic [15:0] OFS_NUM_THREE = 16'h3113;

   // Field positions
   localparam int unsigned REMAP_SEL_BIT = 3;
   localparam int unsigned PWR_SRC_BIT = 0;
   localparam int unsigned STAT_MODE_BIT = 0;
   localparam int unsigned STAT_CNT_LSB = 4;
   localparam int unsigned MAP_HI_LSB = 4;

   // Writable bits and reset values
   localparam logic [7:0] CFG_THREE_MASK = 8'h08;
   localparam logic [7:0] PORT_BITS_MASK = 8'h0e;
   localparam logic [7:0] MAP_THREE_MASK = 8'h0f;
   localparam logic [7:0] PWR_CTRL_MASK = 8'h01;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Strap code to port mask: 0 none, 1 port 1, 2 ports 1-2, 3 ports 1-3
   function automatic logic [7:0] hpmdc_strap_mask(input logic [1:0] code);
      logic [7:0] m;
      m = 8'h00;
      case (code)
         2'd1: m = 8'h02;
         2'd2: m = 8'h06;
         2'd3: m = 8'h0e;
         default: m = 8'h00;
      endcase
      return m;
   endfunction
endpackage

// *** verification/hpmdc_port_cfg_props.sv ***
`timescale 1ns/100ps
module hpmdc_port_cfg_props (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Register port
   input wire logic [15:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   // Report
   input wire logic [3:1] port_enabled_out,
   input wire logic [11:0] port_number_out,
   input wire logic [3:0] port_count_out,
   input wire logic remap_mode_out,
   input wire logic self_powered_out
);
   // One clock domain, so clocking and reset are shared
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   mode_rsvd_read_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 16'h00e6 |->
      (reg_rdata_out & 8'hf7) == 8'h00) else $error("reserved mode bits read back");
   std_identity_a: assert property (!remap_mode_out && port_enabled_out == 3'b111 |->
      port_number_out == 12'h321) else $error("standard numbering not identity");
   std_contig_a: assert property (!remap_mode_out |-> port_number_out[3:0] == {3'b000, port_enabled_out[1]}
      && port_number_out[7:4] == (port_enabled_out[2] ? 4'(port_enabled_out[1]) + 4'd1 : 4'd0))
      else $error("standard numbering has a gap");
   offered_number_a: assert property (port_enabled_out[1] == (port_number_out[3:0] != 0)
      && port_enabled_out[2] == (port_number_out[7:4] != 0) && port_enabled_out[3] == (port_number_out[11:8] != 0))
      else $error("offered flag and number disagree");
   count_sum_a: assert property (port_count_out == 4'($countones(port_enabled_out)))
      else $error("port count wrong");
   mode_write_a: assert property (reg_wr_in && reg_addr_in == 16'h00e6 |-> ##2
      remap_mode_out == $past(reg_wdata_in[3], 2)) else $error("mode did not follow write");
   power_write_a: assert property (reg_wr_in && reg_addr_in == 16'h3100 |-> ##2
      self_powered_out == $past(reg_wdata_in[0], 2)) else $error("power source did not follow write");
   status_read_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 16'h3110 |->
      reg_rdata_out[7:4] == $past(port_count_out) && reg_rdata_out[3:1] == $past(port_enabled_out)
      && reg_rdata_out[0] == $past(remap_mode_out)) else $error("status read wrong");
endmodule
bind hpmdc_port_cfg hpmdc_port_cfg_props props_u (.clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
   .reg_rd_in, .reg_rdata_out, .port_enabled_out, .port_number_out, .port_count_out, .remap_mode_out,
   .self_powered_out);

// *** verification/hpmdc_port_cfg_bench.sv ***
`timescale 1ns/100ps
module hpmdc_port_cfg_bench;
   import hpmdc_pkg::*;
   logic clk_in = 0, resetn_in = 0, reg_wr_in = 0, reg_rd_in = 0, id = 0, mode_o, self_o;
   logic [15:0] reg_addr_in = 0;
   logic [7:0] reg_wdata_in = 0, reg_rdata_out, rg [10];
   logic [1:0] fas = 0, pos = 0;
   logic [3:1] en_o, fr_o, ee, ef;
   logic [11:0] num_o, en_n;
   logic [3:0] cnt_o, ec;
   int error_cnt = 0, check_count = 0, k, a;
   // Index 9 is an unmapped address, so its mask is empty
   logic [15:0] ad [10] = '{16'h00e6, 16'h00e7, 16'h00e8, 16'h00e9, 16'h300a, 16'h300b, 16'h30fb, 16'h30fc,
      16'h3100, 16'h00ea};
   logic [7:0] mk [10] = '{8'h08, 8'h0e, 8'h0e, 8'h0e, 8'h0e, 8'h0e, 8'hff, 8'h0f, 8'h01, 8'h00};
   // Clock
   always #2.5 clk_in = ~clk_in;
   hpmdc_port_cfg dut_u (.clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
      .internal_default_in(id), .fixed_attach_strap_in(fas), .port_off_strap_in(pos), .port_enabled_out(en_o),
      .port_number_out(num_o), .port_count_out(cnt_o), .fixed_attach_report_out(fr_o), .remap_mode_out(mode_o),
      .self_powered_out(self_o));
   // Comparison and closing
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Bus cycles; the model keeps only the bits that are stored
   task automatic wr(input int i, input logic [7:0] d);
      @(posedge clk_in);
      reg_wr_in <= 1;
      reg_addr_in <= ad[i];
      reg_wdata_in <= d;
      @(posedge clk_in);
      reg_wr_in <= 0;
      rg[i] = d & mk[i];
   endtask
   task automatic rd(input logic [15:0] ra, output logic [7:0] d);
      @(posedge clk_in);
      reg_rd_in <= 1;
      reg_addr_in <= ra;
      @(posedge clk_in);
      reg_rd_in <= 0;
      #1 d = reg_rdata_out;
   endtask
   function automatic logic [7:0] sm(input logic [1:0] c);
      return c == 0 ? 8'h00 : c == 1 ? 8'h02 : c == 2 ? 8'h06 : 8'h0e;
   endfunction
   // Reference numbering, walking ports upward so gaps close
   task automatic model();
      logic [7:0] off, fx;
      logic [3:0] n;
      off = id ? sm(pos) : rg[8][0] ? rg[2] | rg[4] : rg[3] | rg[5];
      fx = id ? sm(fas) : rg[1];
      ee = 0;
      ef = 0;
      ec = 0;
      en_n = 0;
      for (int p = 1; p <= 3; p++) begin
         n = rg[0][3] ? (p == 3 ? rg[7][3:0] : rg[6][4*p-4+:4]) : ec + 4'd1;
         if (off[p]) n = 0;
         en_n[4*p-4+:4] = n;
         if (n != 0) begin
            ee[p] = 1;
            ec++;
            if (n <= 3) ef[n] = ef[n] | fx[p];
         end
      end
   endtask
   task automatic compare();
      logic [7:0] d;
      model();
      chk(en_o, ee);
      chk(num_o, en_n);
      chk(cnt_o, ec);
      chk(fr_o, ef);
      chk(mode_o, rg[0][3]);
      chk(self_o, rg[8][0]);
      rd(16'h3110, d);
      chk(d, {ec, ee, rg[0][3]});
   endtask
   // Main sequence: reset values, then random register and strap traffic
   initial begin
      logic [7:0] d;
      void'($urandom(32'hbb88));
      for (k = 0; k < 10; k++) rg[k] = 0;
      repeat (2) @(posedge clk_in);
      resetn_in <= 1;
      repeat (6) @(posedge clk_in);
      for (k = 0; k < 10; k++) begin
         rd(ad[k], d);
         chk(d, 8'h00);
      end
      compare();
      for (k = 0; k < 80; k++) begin
         a = $urandom_range(9);
         wr(a, 8'($urandom));
         rd(ad[a], d);
         chk(d, rg[a]);
         if ($urandom_range(3) == 0) begin
            @(posedge clk_in);
            id <= 1'($urandom);
            fas <= 2'($urandom);
            pos <= 2'($urandom);
            repeat (6) @(posedge clk_in);
         end
         compare();
      end
      stop_test();
   end
endmodule
